// [sch_bus_model.sv]
// Behavioural serial EEPROM and hot-plug expander on the master bus.
// Assumes a pulled-up bus; sda_oe_n low pulls the data wire low.
`timescale 1ns/1ps
`default_nettype none
module sch_bus_model
  import sch_pkg::*;
(
  // Bus wires
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_oe_n,
  // Test control
  input  wire logic       ee_present,
  input  wire logic [7:0] in_byte,
  output logic [7:0]      out_byte,
  output int              writes
);
  logic [7:0] sh = 8'h00;
  logic       sel = 1'b0;
  logic       rd = 1'b0;
  logic       rd_pend = 1'b0;
  logic       mack = 1'b0;
  int         bc = 0;
  int         idx = 0;
  initial begin
    sda_oe_n = 1'b1;
    out_byte = 8'h00;
    writes = 0;
  end
  always @(negedge sda) if (scl) begin
    bc = 0;
    idx = 0;
    rd = 1'b0;
  end
  always @(posedge scl) begin
    bc = bc + 1;
    if (bc <= 8 && !rd) sh = {sh[6:0], sda};
    if (bc == 9 && rd) mack = !sda;
  end
  always @(negedge scl) begin
    if (bc == 8 && !rd) begin
      if (idx == 0) begin
        sel = (sh[7:1] == EXP_ADDR) || (sh[7:1] == EE_ADDR && ee_present);
        rd_pend = sh[0];
        mack = 1'b1;
      end else if (idx == 2 && sel) begin
        out_byte = sh;
        writes = writes + 1;
      end
      idx = idx + 1;
      sda_oe_n = !sel;
    end else if (bc == 8) sda_oe_n = 1'b1;
    else if (bc == 9) begin
      bc = 0;
      rd = rd_pend;
      sh = in_byte;
      sda_oe_n = !(rd && mack && sel) | sh[7];
    end else if (rd && bc >= 1 && bc <= 7 && mack && sel) sda_oe_n = sh[7-bc];
  end
endmodule
`default_nettype wire

// [sch_pkg.sv]
// Shared constants and types of the SMBus configuration and hot-plug expander block.
// Assumes a single 50 MHz system clock and a synchronous active-low reset.
`default_nettype none
package sch_pkg;
  // Timing of the master bus, one bit split in four quarter phases
  localparam int CLK_NS      = 20;
  localparam int MBUS_BIT_NS = 10000;
  localparam int QTR_CYCLES  = (MBUS_BIT_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
  localparam logic [6:0] QTR_LAST = 7'(QTR_CYCLES - 1);

  // Bus addresses and expander commands
  localparam logic [6:0] SLV_ADDR_BASE = 7'h70;
  localparam logic [6:0] EE_ADDR       = 7'h50;
  localparam logic [6:0] EXP_ADDR      = 7'h20;
  localparam logic       DIR_WR        = 1'b0;
  localparam logic       DIR_RD        = 1'b1;
  localparam logic [7:0] EXP_CMD_IN    = 8'h00;
  localparam logic [7:0] EXP_CMD_OUT   = 8'h01;
  localparam logic [7:0] EE_START_PTR  = 8'h00;
  localparam logic [7:0] BYTE_ONES     = 8'hff;

  // Configuration space
  localparam int         CFG_DEPTH   = 16;
  localparam int         CFG_AW      = 4;
  localparam logic [7:0] CFG_LIMIT   = 8'h10;
  localparam logic [7:0] CFG_DEFAULT = 8'h00;
  localparam logic [7:0] REG_GPIO_OE_LO  = 8'h00;
  localparam logic [7:0] REG_GPIO_OE_HI  = 8'h01;
  localparam logic [7:0] REG_GPIO_ALT_LO = 8'h02;
  localparam logic [7:0] REG_GPIO_ALT_HI = 8'h03;
  localparam logic [7:0] REG_GPIO_DO_LO  = 8'h04;
  localparam logic [7:0] REG_GPIO_DO_HI  = 8'h05;
  localparam logic [7:0] REG_GPIO_DI_LO  = 8'h10;
  localparam logic [7:0] REG_GPIO_DI_HI  = 8'h11;
  localparam logic [7:0] REG_HP_IN       = 8'h12;
  localparam logic [7:0] REG_STATUS      = 8'h13;

  // Pins and hot-plug width
  localparam int         GPIO_N     = 9;
  localparam int         IRQ_PIN    = 8;
  localparam int         HP_W       = 8;
  localparam logic [7:0] HP_DEFAULT = 8'h00;

  // Bit and step counters
  localparam logic [3:0] LAST_BIT     = 4'd7;
  localparam logic [3:0] ACK_BIT      = 4'd8;
  localparam logic [4:0] STEP_ADDR    = 5'd0;
  localparam logic [4:0] STEP_CMD     = 5'd1;
  localparam logic [4:0] STEP_RADDR   = 5'd2;
  localparam logic [4:0] EE_FIRST_RD  = 5'd3;
  localparam logic [4:0] EE_LAST_STEP = 5'(2 + CFG_DEPTH);

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } sch_wr_s;

  typedef enum {MB_IDLE, MB_NEXT, MB_START, MB_BIT, MB_STOP} sch_mbit_e;
  typedef enum {J_NONE, J_EE, J_WR, J_RD} sch_job_e;
  typedef enum {SL_IDLE, SL_ADDR, SL_WRITE, SL_READ} sch_slv_e;
endpackage
`default_nettype wire

// [sch_slave.sv]
// Slave SMBus port: byte pointer, then auto-incrementing reads and writes.
// Assumes open-drain pins resolved outside; never stretches the clock.
`timescale 1ns/1ps
`default_nettype none
module sch_slave
  import sch_pkg::*;
(
  // Clock and reset
  input  wire logic    clk,
  input  wire logic    rst_n,
  // Slave bus pins
  input  wire logic    scl_in,
  input  wire logic    sda_in,
  output logic         sda_out,
  output logic         sda_oe_n,
  input  wire logic    addr_sel,
  // Configuration space access
  output logic [7:0]   rd_ptr,
  input  wire logic [7:0] rd_data,
  output logic         wr_valid,
  output sch_wr_s      wr
);
  logic [1:0] scl_sy, sda_sy, sel_sy;
  logic       scl_d, sda_d;
  logic       scl_s, sda_s;
  logic [3:0] bitn;
  logic [7:0] shreg, tx, ptr;
  logic       first, sda_low;
  logic [6:0] my_addr;
  sch_slv_e   st;

  assign scl_s    = scl_sy[1];
  assign sda_s    = sda_sy[1];
  assign my_addr  = {SLV_ADDR_BASE[6:1], sel_sy[1]};
  assign rd_ptr   = ptr;
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~sda_low;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_sy <= 2'b11;
      sda_sy <= 2'b11;
      sel_sy <= 2'b00;
      scl_d  <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      scl_sy <= {scl_sy[0], scl_in};
      sda_sy <= {sda_sy[0], sda_in};
      sel_sy <= {sel_sy[0], addr_sel};
      scl_d  <= scl_s;
      sda_d  <= sda_s;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st       <= SL_IDLE;
      bitn     <= ACK_BIT;
      shreg    <= 8'h00;
      tx       <= 8'h00;
      ptr      <= 8'h00;
      first    <= 1'b0;
      sda_low  <= 1'b0;
      wr_valid <= 1'b0;
      wr       <= '0;
    end else begin
      wr_valid <= 1'b0;
      if (scl_s && scl_d && sda_d && !sda_s) begin
        // Start waits out the first falling edge before counting bits
        st      <= SL_ADDR;
        bitn    <= ACK_BIT;
        sda_low <= 1'b0;
      end else if (scl_s && scl_d && !sda_d && sda_s) begin
        st      <= SL_IDLE;
        sda_low <= 1'b0;
      end else if (st != SL_IDLE) begin
        if (scl_s && !scl_d) begin
          if (bitn != ACK_BIT) begin
            shreg <= {shreg[6:0], sda_s};
          end else if (st == SL_READ && sda_s) begin
            st <= SL_IDLE;
          end
        end else if (!scl_s && scl_d) begin
          if (bitn == LAST_BIT) begin
            bitn <= ACK_BIT;
            case (st)
              SL_ADDR: begin
                if (shreg[7:1] == my_addr) begin
                  sda_low <= 1'b1;
                  st      <= shreg[0] ? SL_READ : SL_WRITE;
                  first   <= 1'b1;
                end else begin
                  st <= SL_IDLE;
                end
              end
              SL_WRITE: begin
                sda_low <= 1'b1;
                if (first) begin
                  ptr   <= shreg;
                  first <= 1'b0;
                end else begin
                  wr_valid <= 1'b1;
                  wr       <= '{addr: ptr, data: shreg};
                  ptr      <= ptr + 8'd1;
                end
              end
              default: sda_low <= 1'b0;
            endcase
          end else if (bitn == ACK_BIT) begin
            bitn <= 4'd0;
            if (st == SL_READ) begin
              tx      <= rd_data;
              sda_low <= ~rd_data[7];
              ptr     <= ptr + 8'd1;
            end else begin
              sda_low <= 1'b0;
            end
          end else begin
            bitn <= bitn + 4'd1;
            if (st == SL_READ) begin
              tx      <= {tx[6:0], 1'b1};
              sda_low <= ~tx[6];
            end
          end
        end
      end
    end
  end

  a_addr_match: assert property (@(posedge clk) disable iff (!rst_n)
    st == SL_ADDR && !scl_s && scl_d && bitn == LAST_BIT && shreg[7:1] != my_addr
    && !(scl_s && scl_d) |=> !sda_low && st == SL_IDLE)
    else $error("slave answered a foreign address");
  a_wr_source: assert property (@(posedge clk) disable iff (!rst_n)
    wr_valid |-> $past(st == SL_WRITE && bitn == LAST_BIT && !first))
    else $error("register write outside a write data byte");
  a_read_release: assert property (@(posedge clk) disable iff (!rst_n)
    st == SL_READ && !scl_s && scl_d && bitn == LAST_BIT |=> !sda_low)
    else $error("slave holds data during master acknowledge");
endmodule
`default_nettype wire

// [sch_top.sv]
// Top of the SMBus block: slave config port, EEPROM loader, expander master, GPIO mux.
// Assumes pins are resolved outside and hot-plug outputs arrive on the system clock.
// Behaviour
// - An external agent reads and writes every configuration register over the slave port.
// - After reset the master loads the configuration space from the serial EEPROM.
// - Master and slave ports use separate pin pairs and work as independent buses.
// - The master never arbitrates and assumes it is alone on its bus.
// - After configuration, any change of hot-plug outputs causes one write of all of them.
// - An expander interrupt starts a read of all hot-plug inputs.
// - Hot-plug control through the expander covers every downstream port.
// - Signals named with an n suffix are asserted low.
// - Nine general-purpose pins each act as input, output or alternate function.
// - Alternate functions are chosen by software, the slave port or the EEPROM load.
// - The slave answers only at the address picked by its address-select pin.
// - The master clock toggles only during EEPROM or expander accesses.
// - The expander interrupt is the first alternate function of pin eight.
`timescale 1ns/1ps
`default_nettype none
module sch_top
  import sch_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Master bus pins
  input  wire logic              master_bus_clock_in,
  output logic                   master_bus_clock_out,
  output logic                   master_bus_clock_oe_n,
  input  wire logic              master_bus_data_in,
  output logic                   master_bus_data_out,
  output logic                   master_bus_data_oe_n,
  // Slave bus pins
  input  wire logic              slave_bus_clock_in,
  output logic                   slave_bus_clock_out,
  output logic                   slave_bus_clock_oe_n,
  input  wire logic              slave_bus_data_in,
  output logic                   slave_bus_data_out,
  output logic                   slave_bus_data_oe_n,
  input  wire logic              slave_addr_select_pin,
  // General-purpose pins
  input  wire logic [GPIO_N-1:0] gpio_in,
  output logic [GPIO_N-1:0]      gpio_out,
  output logic [GPIO_N-1:0]      gpio_oe_n,
  // Hot-plug controller side
  input  wire logic [HP_W-1:0]   hp_out,
  output logic [HP_W-1:0]        hp_in,
  output logic                   hp_in_valid,
  // On-chip software write port
  input  wire logic              sw_wr_valid,
  input  wire sch_wr_s           sw_wr,
  // Status
  output logic                   cfg_done,
  output logic                   ee_fail
);
  logic [7:0]        cfg_mem [0:CFG_DEPTH-1];
  logic [GPIO_N-1:0] gpio_sy1, gpio_s;
  logic [GPIO_N-1:0] gpio_en, gpio_alt, gpio_do;
  logic              msda_sy1, msda_s;
  logic              expander_irq_n, irq_asserted;
  logic [7:0]        slv_ptr, slv_rd;
  logic              slv_wr_valid;
  sch_wr_s           slv_wr;
  logic              ee_wr_valid;
  sch_wr_s           ee_wr;
  logic [6:0]        qcnt;
  logic              tick;
  sch_mbit_e         mst;
  sch_job_e          job;
  logic [4:0]        step;
  logic [1:0]        phase;
  logic [3:0]        bitn;
  logic [7:0]        shreg, rx;
  logic              scl_low, sda_low, nack;
  logic [HP_W-1:0]   hp_sent;
  logic              op_start, op_read, op_ack, op_last;
  logic [7:0]        op_byte;

  sch_slave u_slave (
    .clk      (clk),
    .rst_n    (rst_n),
    .scl_in   (slave_bus_clock_in),
    .sda_in   (slave_bus_data_in),
    .sda_out  (slave_bus_data_out),
    .sda_oe_n (slave_bus_data_oe_n),
    .addr_sel (slave_addr_select_pin),
    .rd_ptr   (slv_ptr),
    .rd_data  (slv_rd),
    .wr_valid (slv_wr_valid),
    .wr       (slv_wr)
  );
  assign slave_bus_clock_out   = 1'b0;
  assign slave_bus_clock_oe_n  = 1'b1;
  assign master_bus_clock_out  = 1'b0;
  assign master_bus_clock_oe_n = ~scl_low;
  assign master_bus_data_out   = 1'b0;
  assign master_bus_data_oe_n  = ~sda_low;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gpio_sy1 <= '1;
      gpio_s   <= '1;
      msda_sy1 <= 1'b1;
      msda_s   <= 1'b1;
    end else begin
      gpio_sy1 <= gpio_in;
      gpio_s   <= gpio_sy1;
      msda_sy1 <= master_bus_data_in;
      msda_s   <= msda_sy1;
    end
  end

  always_comb begin
    gpio_en  = {cfg_mem[REG_GPIO_OE_HI[CFG_AW-1:0]][0], cfg_mem[REG_GPIO_OE_LO[CFG_AW-1:0]]};
    gpio_alt = {cfg_mem[REG_GPIO_ALT_HI[CFG_AW-1:0]][0], cfg_mem[REG_GPIO_ALT_LO[CFG_AW-1:0]]};
    gpio_do  = {cfg_mem[REG_GPIO_DO_HI[CFG_AW-1:0]][0], cfg_mem[REG_GPIO_DO_LO[CFG_AW-1:0]]};
  end

  assign expander_irq_n = gpio_s[IRQ_PIN];
  // interrupt only in alternate mode of pin eight
  assign irq_asserted   = gpio_alt[IRQ_PIN] & ~expander_irq_n;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gpio_out  <= '0;
      gpio_oe_n <= '1;
    end else begin
      // Other alternate functions live elsewhere; the pin is left undriven here
      gpio_oe_n <= ~(gpio_en & ~gpio_alt);
      gpio_out  <= gpio_do & gpio_en & ~gpio_alt;
    end
  end

  // three writers of the configuration space
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < CFG_DEPTH; i++) begin
        cfg_mem[i] <= CFG_DEFAULT;
      end
    end else if (ee_wr_valid) begin
      cfg_mem[ee_wr.addr[CFG_AW-1:0]] <= ee_wr.data;
    end else if (slv_wr_valid && slv_wr.addr < CFG_LIMIT) begin
      // A colliding lower-priority write is dropped; sources rarely overlap
      cfg_mem[slv_wr.addr[CFG_AW-1:0]] <= slv_wr.data;
    end else if (sw_wr_valid && sw_wr.addr < CFG_LIMIT) begin
      cfg_mem[sw_wr.addr[CFG_AW-1:0]] <= sw_wr.data;
    end
  end

  // read decode for the slave port
  always_comb begin
    if (slv_ptr < CFG_LIMIT) begin
      slv_rd = cfg_mem[slv_ptr[CFG_AW-1:0]];
    end else if (slv_ptr == REG_GPIO_DI_LO) begin
      slv_rd = gpio_s[7:0];
    end else if (slv_ptr == REG_GPIO_DI_HI) begin
      slv_rd = {7'h00, gpio_s[IRQ_PIN]};
    end else if (slv_ptr == REG_HP_IN) begin
      slv_rd = hp_in;
    end else if (slv_ptr == REG_STATUS) begin
      slv_rd = {6'h00, ee_fail, cfg_done};
    end else begin
      slv_rd = 8'h00;
    end
  end

  // Quarter-bit enable for the master bus
  always_ff @(posedge clk) begin
    if (!rst_n || tick) begin
      qcnt <= 7'h00;
    end else begin
      qcnt <= qcnt + 7'h01;
    end
  end
  assign tick = (qcnt == QTR_LAST);

  // Byte plan of each job, indexed by step
  always_comb begin
    op_start = 1'b0;
    op_read  = 1'b0;
    op_ack   = 1'b0;
    op_last  = 1'b0;
    op_byte  = BYTE_ONES;
    case (job)
      J_EE: begin
        if (step == STEP_ADDR) begin
          op_start = 1'b1;
          op_byte  = {EE_ADDR, DIR_WR};
        end else if (step == STEP_CMD) begin
          op_byte = EE_START_PTR;
        end else if (step == STEP_RADDR) begin
          op_start = 1'b1;
          op_byte  = {EE_ADDR, DIR_RD};
        end else begin
          op_read = 1'b1;
          op_ack  = (step != EE_LAST_STEP);
          op_last = (step == EE_LAST_STEP);
        end
      end
      J_WR: begin
        if (step == STEP_ADDR) begin
          op_start = 1'b1;
          op_byte  = {EXP_ADDR, DIR_WR};
        end else if (step == STEP_CMD) begin
          op_byte = EXP_CMD_OUT;
        end else begin
          op_byte = hp_sent;
          op_last = 1'b1;
        end
      end
      J_RD: begin
        if (step == STEP_ADDR) begin
          op_start = 1'b1;
          op_byte  = {EXP_ADDR, DIR_WR};
        end else if (step == STEP_CMD) begin
          op_byte = EXP_CMD_IN;
        end else if (step == STEP_RADDR) begin
          op_start = 1'b1;
          op_byte  = {EXP_ADDR, DIR_RD};
        end else begin
          op_read = 1'b1;
          op_last = 1'b1;
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mst         <= MB_IDLE;
      job         <= J_NONE;
      step        <= STEP_ADDR;
      phase       <= 2'd0;
      bitn        <= 4'd0;
      shreg       <= BYTE_ONES;
      rx          <= 8'h00;
      scl_low     <= 1'b0;
      sda_low     <= 1'b0;
      nack        <= 1'b0;
      cfg_done    <= 1'b0;
      ee_fail     <= 1'b0;
      hp_sent     <= HP_DEFAULT;
      hp_in       <= HP_DEFAULT;
      hp_in_valid <= 1'b0;
      ee_wr_valid <= 1'b0;
      ee_wr       <= '0;
    end else begin
      ee_wr_valid <= 1'b0;
      hp_in_valid <= 1'b0;
      if (mst == MB_IDLE) begin
        step <= STEP_ADDR;
        // EEPROM first, then one expander job at a time
        if (!cfg_done) begin
          job <= J_EE;
          mst <= MB_NEXT;
        end else if (hp_out != hp_sent) begin
          // write all hot-plug outputs on change
          job     <= J_WR;
          hp_sent <= hp_out;
          mst     <= MB_NEXT;
        end else if (irq_asserted) begin
          job <= J_RD;
          mst <= MB_NEXT;
        end
      end else if (tick) begin
        phase <= phase + 2'd1;
        case (mst)
          MB_NEXT: begin
            phase <= 2'd0;
            bitn  <= 4'd0;
            shreg <= op_byte;
            mst   <= op_start ? MB_START : MB_BIT;
          end
          MB_START: begin
            case (phase)
              2'd0: sda_low <= 1'b0;
              2'd1: scl_low <= 1'b0;
              2'd2: sda_low <= 1'b1;
              default: begin
                scl_low <= 1'b1;
                mst     <= MB_BIT;
              end
            endcase
          end
          MB_BIT: begin
            case (phase)
              2'd0: sda_low <= (bitn == ACK_BIT) ? (op_read & op_ack) : ~shreg[7];
              2'd1: scl_low <= 1'b0;
              2'd2: begin
                if (bitn == ACK_BIT) begin
                  nack <= msda_s;
                end else begin
                  rx <= {rx[6:0], msda_s};
                end
              end
              default: begin
                scl_low <= 1'b1;
                if (bitn != ACK_BIT) begin
                  bitn  <= bitn + 4'd1;
                  shreg <= {shreg[6:0], 1'b1};
                end else if (!op_read && nack) begin
                  // Missing slave ends the job; EEPROM defaults stay in place
                  mst <= MB_STOP;
                  if (job == J_EE) begin
                    ee_fail <= 1'b1;
                  end
                end else begin
                  if (op_read && job == J_EE) begin
                    ee_wr_valid <= 1'b1;
                    ee_wr       <= '{addr: {3'h0, step - EE_FIRST_RD}, data: rx};
                  end else if (op_read) begin
                    hp_in       <= rx;
                    hp_in_valid <= 1'b1;
                  end
                  if (op_last) begin
                    mst <= MB_STOP;
                  end else begin
                    step <= step + 5'd1;
                    mst  <= MB_NEXT;
                  end
                end
              end
            endcase
          end
          default: begin
            case (phase)
              2'd0: sda_low <= 1'b1;
              2'd1: scl_low <= 1'b0;
              2'd2: sda_low <= 1'b0;
              default: begin
                mst <= MB_IDLE;
                job <= J_NONE;
                if (job == J_EE) begin
                  cfg_done <= 1'b1;
                end
              end
            endcase
          end
        endcase
      end
    end
  end

  a_scl_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    mst == MB_IDLE |-> !scl_low && !sda_low)
    else $error("master bus driven while idle");
  a_ee_first: assert property (@(posedge clk) disable iff (!rst_n)
    (job == J_WR || job == J_RD) |-> cfg_done)
    else $error("expander job before configuration load");
  a_one_job: assert property (@(posedge clk) disable iff (!rst_n)
    mst != MB_IDLE && $past(mst) != MB_IDLE |-> $stable(job))
    else $error("job changed mid transaction");
  a_hp_write: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_done && mst == MB_IDLE && hp_out != hp_sent
    |=> job == J_WR && hp_sent == $past(hp_out))
    else $error("hot-plug output change not written");
  a_irq_read: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_done && mst == MB_IDLE && hp_out == hp_sent && irq_asserted |=> job == J_RD)
    else $error("expander interrupt not serviced");
  a_irq_pin: assert property (@(posedge clk) disable iff (!rst_n)
    gpio_alt[IRQ_PIN] |=> gpio_oe_n[IRQ_PIN])
    else $error("interrupt pin driven in alternate mode");
endmodule
`default_nettype wire

// [test_smbus_config_and_hotplug_expander.sv]
// Self-checking bench: slave-bus host tasks, pin checks, master-bus model.
// Assumes the package constants and pulled-up wires on both buses.
`timescale 1ns/1ps
`default_nettype none
module test_smbus_config_and_hotplug_expander
  import sch_pkg::*;
;
  logic       clk, rst_n, scl_t, sda_t, last, sel_pin, sw_v, ee_pres, m_rel, k, bad;
  logic [8:0] gpio_in, gpio_out, gpio_oe_n;
  logic [7:0] hp_out, hp_in, exp_in, ex_out, v;
  logic       m_scl, m_sda_oe_n, s_sda_oe_n, hp_v, cfg_done, ee_fail;
  sch_wr_s    sw;
  int         mismatches = 0, checked = 0, cycles = 0, writes, i;
  logic [7:0] rp [6] = '{8'h00, 8'h02, 8'h04, 8'h0f, 8'h10, 8'h13};
  logic [7:0] rw [6] = '{8'h0f, 8'h01, 8'h05, 8'ha7, 8'h77, 8'h55};
  logic [7:0] re [6] = '{8'h0f, 8'h01, 8'h05, 8'ha7, 8'ha5, 8'h03};
  wire        m_sda = m_sda_oe_n & m_rel;
  wire        s_sda = sda_t & s_sda_oe_n;
  sch_top sch_top_i (.clk(clk), .rst_n(rst_n), .master_bus_clock_in(m_scl),
    .master_bus_clock_out(), .master_bus_clock_oe_n(m_scl), .master_bus_data_in(m_sda),
    .master_bus_data_out(), .master_bus_data_oe_n(m_sda_oe_n), .slave_bus_clock_in(scl_t),
    .slave_bus_clock_out(), .slave_bus_clock_oe_n(), .slave_bus_data_in(s_sda),
    .slave_bus_data_out(), .slave_bus_data_oe_n(s_sda_oe_n), .slave_addr_select_pin(sel_pin),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .hp_out(hp_out),
    .hp_in(hp_in), .hp_in_valid(hp_v), .sw_wr_valid(sw_v), .sw_wr(sw),
    .cfg_done(cfg_done), .ee_fail(ee_fail));
  sch_bus_model sch_bus_model_i (.scl(m_scl), .sda(m_sda), .sda_oe_n(m_rel),
    .ee_present(ee_pres), .in_byte(exp_in), .out_byte(ex_out), .writes(writes));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Ceiling well above the roughly 70k cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic sq(input logic c, input logic d);
    scl_t = c;
    sda_t = d;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Data moves while the clock is low; a b differing from a moves it while high, a start or stop
  task automatic cond(input logic a, input logic b);
    sq(1'b0, last);
    sq(1'b0, a);
    sq(1'b1, a);
    sq(1'b1, b);
    last = b;
  endtask
  task automatic sbyte(input logic [7:0] b, output logic ack);
    for (int j = 7; j >= 0; j--) cond(b[j], b[j]);
    cond(1'b1, 1'b1);
    ack = !s_sda;
  endtask
  task automatic swr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                     output logic ack);
    logic k2;
    cond(1'b1, 1'b0);
    sbyte({a, DIR_WR}, ack);
    sbyte(p, k2);
    sbyte(d, k2);
    cond(1'b0, 1'b1);
  endtask
  task automatic srd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] r);
    logic k2;
    cond(1'b1, 1'b0);
    sbyte({a, DIR_WR}, k2);
    sbyte(p, k2);
    cond(1'b1, 1'b0);
    sbyte({a, DIR_RD}, k2);
    for (int j = 7; j >= 0; j--) begin
      cond(1'b1, 1'b1);
      r[j] = s_sda;
    end
    cond(1'b1, 1'b1);
    cond(1'b0, 1'b1);
  endtask
  initial begin
    rst_n = 1'b0;
    {scl_t, sda_t, last, sel_pin, sw_v, ee_pres} = 6'b111000;
    sw = '0;
    exp_in = 8'h96;
    hp_out = 8'h00;
    gpio_in = 9'h0a5;
    repeat (3) @(posedge clk);
    #1;
    chk("reset enables", gpio_oe_n, 9'h1ff);
    rst_n = 1'b1;
    hp_out = 8'h3c;
    for (i = 0; i < 20000 && cfg_done !== 1'b1; i++) @(posedge clk);
    #1;
    chk("early writes", 9'(writes), 9'h000);
    chk("load status", {7'h00, ee_fail, cfg_done}, 9'h003);
    for (i = 0; i < 30000 && writes == 0; i++) @(posedge clk);
    #1;
    chk("hot-plug byte", {1'b0, ex_out}, 9'h03c);
    repeat (2000) @(posedge clk);
    bad = 1'b0;
    for (i = 0; i < 2000; i++) begin
      @(posedge clk);
      #1;
      bad = bad | !m_scl;
    end
    chk("idle clock", {8'h00, bad}, 9'h000);
    chk("write count", 9'(writes), 9'h001);
    $display("done: load and write");
    for (int r = 0; r < 6; r++) begin
      swr(7'h70, rp[r], rw[r], k);
      srd(7'h70, rp[r], v);
      chk("row ack", {8'h00, k}, 9'h001);
      chk("row data", {1'b0, v}, {1'b0, re[r]});
    end
    chk("pin enables", gpio_oe_n, 9'h1f1);
    chk("pin data", {8'h00, gpio_out[2]}, 9'h001);
    swr(7'h71, 8'h0f, 8'h11, k);
    chk("foreign ack", {8'h00, k}, 9'h000);
    sel_pin = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    srd(7'h71, 8'h0f, v);
    chk("moved address", {1'b0, v}, 9'h0a7);
    sel_pin = 1'b0;
    sw = '{addr: 8'h01, data: 8'h01};
    sw_v = 1'b1;
    @(posedge clk);
    #1;
    sw_v = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("software enable", {8'h00, gpio_oe_n[8]}, 9'h000);
    $display("done: slave port");
    repeat (4) @(posedge clk);
    #1;
    swr(7'h70, 8'h03, 8'h01, k);
    chk("alt pin", {8'h00, gpio_oe_n[8]}, 9'h001);
    for (i = 0; i < 2000 && m_scl !== 1'b0; i++) @(posedge clk);
    #1;
    gpio_in[8] = 1'b1;
    for (i = 0; i < 30000 && hp_v !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("hot-plug inputs", {1'b0, hp_in}, 9'h096);
    srd(7'h70, 8'h12, v);
    chk("inputs by slave", {1'b0, v}, 9'h096);
    $display("done: interrupt read");
    // Second reset, now with the EEPROM fitted; only the first byte is awaited
    rst_n = 1'b0;
    ee_pres = 1'b1;
    exp_in = 8'h5a;
    repeat (3) @(posedge clk);
    #1;
    chk("reset status", {7'h00, ee_fail, cfg_done}, 9'h000);
    rst_n = 1'b1;
    repeat (20000) @(posedge clk);
    #1;
    srd(7'h70, 8'h00, v);
    chk("first loaded byte", {1'b0, v}, 9'h05a);
    chk("load busy", {7'h00, ee_fail, cfg_done}, 9'h000);
    $display("done: configuration load");
    complete_run();
  end
endmodule
`default_nettype wire
